// ### frame_ram.sv
// Byte buffer for one received request frame.
// Single clock; read data appear one cycle after the address.
`timescale 1ns/1ns
module frame_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ### host_model.sv
// Host master model: frames requests onto rxd, gathers reply bytes from txd.
// Assumes the bench sets parity (0 none, 1 even, 2 odd) and the bit time in cycles.
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    output logic rxd,
    input wire logic txd,
    input wire logic txd_oe
);
    int div = 32;
    int par = 0;
    int par_err = 0;
    logic [7:0] rx_q[$];
    // Master holds the idle line high, never floats it
    initial rxd = 1'b1;
    task automatic send_frame(input logic [7:0] f[$]);
        foreach (f[i]) begin
            for (int k = 0; k < (par != 0 ? 11 : 10); k++) begin
                rxd <= k == 0 ? 1'b0 : k < 9 ? f[i][k - 1] :
                       (k == 9 && par != 0) ? ^f[i] ^ (par == 2) : 1'b1;
                repeat (div) @(negedge clk);
            end
        end
    endtask
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge clk);
            if (txd_oe && !txd) begin
                repeat (div / 2) @(negedge clk);
                for (int k = 0; k < 8; k++) begin
                    repeat (div) @(negedge clk);
                    b[k] = txd;
                end
                rx_q.push_back(b);
                if (par != 0) begin
                    repeat (div) @(negedge clk);
                    if (txd !== (^b ^ (par == 2))) par_err++;
                end
                repeat (div) @(negedge clk);
            end
        end
    end
endmodule

// ### modbus_pkg.sv
// Shared constants and types for the serial register port.
// Assumes a single 125 MHz clock domain.
package modbus_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int RESP_MAX_MS = 100;
    localparam int RELEASE_MAX_MS = 2;
    // Longest times, rounded down to whole cycles
    localparam int RESP_MAX_CYC = CLK_HZ / 1000 * RESP_MAX_MS;
    localparam int RELEASE_MAX_CYC = CLK_HZ / 1000 * RELEASE_MAX_MS;
    // 3.5 characters of 11 bits, rounded up to whole bits
    localparam int SILENCE_BITS = 39;
    localparam int FRAME_BYTES = 256;
    localparam int BAUD_RST = 9600;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_RST);
    localparam logic [15:0] BAUD_DIV_MIN = 16'h0010;

    // ------------------------------------------------------------
    // Protocol codes
    // ------------------------------------------------------------
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] NODE_MAX = 8'hf7;
    localparam logic [7:0] NODE_RST = 8'h01;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_COIL = 8'h05;
    localparam logic [7:0] FC_WR1 = 8'h06;
    localparam logic [7:0] FC_WRN = 8'h10;
    localparam logic [7:0] FC_EXC = 8'h80;
    localparam logic [7:0] EX_FUNC = 8'h01;
    localparam logic [7:0] EX_ADDR = 8'h02;
    localparam logic [7:0] EX_VAL = 8'h03;
    localparam logic [15:0] RD_QTY_MAX = 16'h007d;
    localparam logic [15:0] WR_QTY_MAX = 16'h007b;
    localparam logic [15:0] COIL_ON = 16'hff00;
    localparam logic [15:0] COIL_OFF = 16'h0000;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    // ------------------------------------------------------------
    // Holding register map and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] REG_SP = 16'h0000;
    localparam logic [15:0] REG_PV = 16'h0001;
    localparam logic [15:0] REG_SPLO = 16'h0010;
    localparam logic [15:0] REG_SPHI = 16'h0011;
    localparam logic [15:0] REG_NODE = 16'h0012;
    localparam logic [15:0] REG_PAR = 16'h0013;
    localparam logic [15:0] REG_BAUD = 16'h0014;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [15:0] SPLO_RST = 16'hf831;
    localparam logic [15:0] SPHI_RST = 16'h270f;

    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;

    typedef struct packed {
        logic [15:0] baud_div;
        parity_t parity;
        logic [7:0] node;
    } ser_cfg_t;

    localparam ser_cfg_t CFG_RST = '{BAUD_DIV_RST, PAR_NONE, NODE_RST};

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

endpackage

// ### modbus_rtu_slave.sv
// RTU slave on a two-wire half-duplex line, serving 16-bit holding registers.
// Assumes rxd is asynchronous; process value and external setpoint are on clk.
`timescale 1ns/1ns
module modbus_rtu_slave
    import modbus_pkg::*;
#(
    parameter int RESP_MAX = RESP_MAX_CYC,
    parameter int RELEASE_MAX = RELEASE_MAX_CYC,
    parameter logic [15:0] BAUD_DIV_INIT = BAUD_DIV_RST
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rxd,
    output logic txd,
    output logic txd_oe,
    input wire logic [15:0] measured_process_value,
    input wire logic [15:0] ext_setpoint,
    input wire logic ext_setpoint_valid,
    output logic [15:0] main_setpoint,
    output logic coil_state
);
    typedef enum logic [2:0] {S_RX, S_DECIDE, S_WR16, S_TX, S_HOLD} state_t;
    localparam ser_cfg_t CFG_INIT = '{BAUD_DIV_INIT, PAR_NONE, NODE_RST};

    state_t st_q, st_d;
    ser_cfg_t cfg_q, cfg_reg_q;
    logic rx_s1_q, rx_s2_q, rx_busy_q, rx_pbad_q, rx_stb_q, rx_err_q;
    logic [3:0] rx_bit_q;
    logic [15:0] rx_tmr_q;
    logic [7:0] rx_sh_q;
    logic [8:0] cnt_q;
    logic [15:0] crc_q;
    logic ferr_q;
    logic [7:0] hdr_q [0:7];
    logic [21:0] sil_q;
    logic [15:0] sp_q, splo_q, sphi_q;
    logic [7:0] exc_q, wi_q, hi_q, rd_data;
    logic [1:0] ph_q;
    logic [8:0] ti_q;
    logic [3:0] tb_q;
    logic [15:0] tt_q, tcrc_q;
    logic [9:0] tsh_q;
    logic tload_q, txd_q, txd_oe_q, coil_q;
    logic [31:0] wd_q;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic range_ok(input logic [15:0] a, input logic [15:0] q);
        logic [16:0] e;
        e = 17'(a) + 17'(q) - 17'h1;
        return (e <= 17'(REG_PV)) || (a >= REG_SPLO && e <= 17'(REG_BAUD));
    endfunction

    function automatic logic value_ok(input logic [15:0] a, input logic [15:0] v);
        if (a == REG_NODE) return v != 16'h0 && v <= 16'(NODE_MAX);
        else if (a == REG_PAR) return v <= 16'h0002;
        else if (a == REG_BAUD) return v >= BAUD_DIV_MIN;
        else return 1'b1;
    endfunction

    function automatic logic [15:0] reg_read(input logic [15:0] a);
        if (a == REG_SP) return ext_setpoint_valid ? ext_setpoint : sp_q;
        else if (a == REG_PV) return measured_process_value;
        else if (a == REG_SPLO) return splo_q;
        else if (a == REG_SPHI) return sphi_q;
        else if (a == REG_NODE) return {8'h00, cfg_reg_q.node};
        else if (a == REG_PAR) return {14'h0, cfg_reg_q.parity};
        else if (a == REG_BAUD) return cfg_reg_q.baud_div;
        else return 16'h0000;
    endfunction

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire [7:0] fc = hdr_q[1];
    wire [15:0] ra = {hdr_q[2], hdr_q[3]};
    wire [15:0] rv = {hdr_q[4], hdr_q[5]};
    wire [15:0] qty2 = {rv[14:0], 1'b0};
    wire par_on = cfg_q.parity != PAR_NONE;
    wire par_odd = cfg_q.parity == PAR_ODD;
    wire [3:0] last_bit = par_on ? 4'ha : 4'h9;
    wire exp_par = ^rx_sh_q ^ par_odd;
    wire [21:0] t35 = 22'(32'(cfg_q.baud_div) * SILENCE_BITS);
    wire eof = st_q == S_RX && cnt_q != 9'h0 && sil_q == t35;
    wire frame_ok = !ferr_q && crc_q == 16'h0 && cnt_q >= 9'h4;
    wire bcast = hdr_q[0] == BCAST_ADDR;
    wire go = frame_ok && (bcast || hdr_q[0] == cfg_q.node);
    wire [8:0] wrn_len = 9'(qty2) + 9'h9;
    wire wrn_pv = !(ra > REG_PV || (ra == REG_SP && rv == 16'h1));
    wire [7:0] exc =
        fc == FC_READ ? ((cnt_q != 9'h8 || rv == 16'h0 || rv > RD_QTY_MAX) ? EX_VAL :
                         range_ok(ra, rv) ? 8'h00 : EX_ADDR) :
        fc == FC_WR1 ? (cnt_q != 9'h8 ? EX_VAL :
                        (!range_ok(ra, 16'h1) || ra == REG_PV) ? EX_ADDR :
                        value_ok(ra, rv) ? 8'h00 : EX_VAL) :
        fc == FC_COIL ? (cnt_q != 9'h8 ? EX_VAL : ra != 16'h0 ? EX_ADDR :
                         (rv == COIL_ON || rv == COIL_OFF) ? 8'h00 : EX_VAL) :
        fc == FC_WRN ? ((rv == 16'h0 || rv > WR_QTY_MAX || 16'(hdr_q[6]) != qty2 ||
                         cnt_q != wrn_len) ? EX_VAL :
                        (range_ok(ra, rv) && !wrn_pv) ? 8'h00 : EX_ADDR) :
        EX_FUNC;
    wire go_ok = go && exc == 8'h00;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    wire wr_en = (st_q == S_DECIDE && go_ok && fc == FC_WR1) ||
                 (st_q == S_WR16 && ph_q == 2'h2);
    wire [15:0] wr_a = st_q == S_WR16 ? ra + 16'(wi_q) : ra;
    wire [15:0] wr_v = st_q == S_WR16 ? {hi_q, rd_data} : rv;
    wire [15:0] clamp = $signed(wr_v) < $signed(splo_q) ? splo_q :
                        $signed(wr_v) > $signed(sphi_q) ? sphi_q : wr_v;
    wire wr16_last = wi_q == 8'(rv - 16'h1);
    wire [7:0] rd_addr = 8'(9'h7 + {wi_q, 1'b0} + 9'(ph_q == 2'h1));

    // ------------------------------------------------------------
    // Reply bytes
    // ------------------------------------------------------------
    wire [8:0] plen = exc_q != 8'h0 ? 9'h1 : fc == FC_READ ? 9'(qty2) + 9'h1 : 9'h4;
    wire [8:0] rlen = plen + 9'h4;
    wire [8:0] p = ti_q - 9'h2;
    wire [8:0] pm = p - 9'h1;
    wire [15:0] rword = reg_read(ra + 16'(pm[8:1]));
    wire [7:0] pay = exc_q != 8'h0 ? exc_q :
                     fc == FC_READ ? (p == 9'h0 ? qty2[7:0] :
                                      pm[0] ? rword[7:0] : rword[15:8]) :
                     hdr_q[3'(p + 9'h2)];
    wire [7:0] tbyte = ti_q == 9'h0 ? hdr_q[0] :
                       ti_q == 9'h1 ? (exc_q != 8'h0 ? (fc | FC_EXC) : fc) :
                       ti_q == rlen - 9'h2 ? tcrc_q[7:0] :
                       ti_q == rlen - 9'h1 ? tcrc_q[15:8] : pay;
    wire tpar = ^tbyte ^ par_odd;
    wire [3:0] tnb = par_on ? 4'hb : 4'ha;
    // Release after one idle bit, never later than the allowed bound
    wire hold_done = wd_q >= 32'(cfg_q.baud_div) || wd_q >= 32'(RELEASE_MAX - 1);

    frame_ram #(.WIDTH(8), .DEPTH(FRAME_BYTES)) u_ram (
        .clk(clk),
        .ce(ce),
        .wr_en(st_q == S_RX && rx_stb_q && cnt_q < 9'(FRAME_BYTES)),
        .wr_addr(cnt_q[7:0]),
        .wr_data(rx_sh_q),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_busy_q <= 1'b0;
            rx_bit_q <= 4'h0;
            rx_tmr_q <= 16'h0;
            rx_sh_q <= 8'h00;
            rx_pbad_q <= 1'b0;
            rx_stb_q <= 1'b0;
            rx_err_q <= 1'b0;
        end else if (ce) begin
            rx_s1_q <= rxd;
            rx_s2_q <= rx_s1_q;
            rx_stb_q <= 1'b0;
            // Own transmission is not listened to on the shared pair
            if (!rx_busy_q) begin
                if (st_q == S_RX && !rx_s2_q) begin
                    rx_busy_q <= 1'b1;
                    rx_tmr_q <= {1'b0, cfg_q.baud_div[15:1]};
                    rx_bit_q <= 4'h0;
                    rx_pbad_q <= 1'b0;
                end
            end else if (rx_tmr_q != 16'h0) begin
                rx_tmr_q <= rx_tmr_q - 16'h1;
            end else begin
                rx_tmr_q <= cfg_q.baud_div - 16'h1;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0) begin
                    if (rx_s2_q) rx_busy_q <= 1'b0;
                end else if (rx_bit_q <= 4'h8) begin
                    rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
                end else if (rx_bit_q != last_bit) begin
                    rx_pbad_q <= rx_s2_q != exp_par;
                end else begin
                    rx_busy_q <= 1'b0;
                    rx_stb_q <= 1'b1;
                    rx_err_q <= !rx_s2_q || rx_pbad_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Frame capture and silence timing
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 9'h0;
            crc_q <= CRC_INIT;
            ferr_q <= 1'b0;
            sil_q <= 22'h0;
            for (int i = 0; i < 8; i++) hdr_q[i] <= 8'h00;
        end else if (ce) begin
            if (st_q != S_RX || rx_busy_q || !rx_s2_q) sil_q <= 22'h0;
            else if (sil_q != t35) sil_q <= sil_q + 22'h1;
            if (st_q == S_DECIDE) begin
                cnt_q <= 9'h0;
                crc_q <= CRC_INIT;
                ferr_q <= 1'b0;
            end else if (st_q == S_RX && rx_stb_q) begin
                if (cnt_q == 9'(FRAME_BYTES)) begin
                    ferr_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 9'h1;
                    crc_q <= crc_step(crc_q, rx_sh_q);
                    ferr_q <= ferr_q | rx_err_q;
                    if (cnt_q < 9'h8) hdr_q[3'(cnt_q)] <= rx_sh_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_RX: if (eof) st_d = S_DECIDE;
            S_DECIDE: begin
                if (go_ok && fc == FC_WRN) st_d = S_WR16;
                else if (go && !bcast) st_d = S_TX;
                else st_d = S_RX;
            end
            S_WR16: begin
                if (wd_q >= 32'(RESP_MAX - 1)) st_d = S_RX;
                else if (ph_q == 2'h2 && wr16_last) st_d = bcast ? S_RX : S_TX;
            end
            S_TX: if (tload_q && ti_q == rlen) st_d = S_HOLD;
            S_HOLD: if (hold_done) st_d = S_RX;
            default: st_d = S_RX;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= S_RX;
            wd_q <= 32'h0;
            txd_oe_q <= 1'b0;
            cfg_q <= CFG_INIT;
            exc_q <= 8'h00;
        end else if (ce) begin
            st_q <= st_d;
            wd_q <= st_d != st_q ? 32'h0 : wd_q + 32'h1;
            txd_oe_q <= st_d == S_TX || st_d == S_HOLD;
            if (st_q == S_DECIDE) exc_q <= exc;
            // Only while idle: a reply still uses the old settings, a broadcast write has landed
            if (st_q == S_RX && cnt_q == 9'h0 && !rx_busy_q) cfg_q <= cfg_reg_q;
        end
    end

    // ------------------------------------------------------------
    // Multiple-register write walk
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wi_q <= 8'h00;
            ph_q <= 2'h0;
            hi_q <= 8'h00;
        end else if (ce) begin
            if (st_q != S_WR16) begin
                wi_q <= 8'h00;
                ph_q <= 2'h0;
            end else begin
                ph_q <= ph_q == 2'h2 ? 2'h0 : ph_q + 2'h1;
                if (ph_q == 2'h1) hi_q <= rd_data;
                if (ph_q == 2'h2) wi_q <= wi_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ti_q <= 9'h0;
            tb_q <= 4'h0;
            tt_q <= 16'h0;
            tsh_q <= 10'h3ff;
            tload_q <= 1'b1;
            tcrc_q <= CRC_INIT;
            txd_q <= 1'b1;
        end else if (ce) begin
            if (st_q != S_TX) begin
                ti_q <= 9'h0;
                tload_q <= 1'b1;
                tcrc_q <= CRC_INIT;
                txd_q <= 1'b1;
            end else if (tload_q) begin
                if (ti_q != rlen) begin
                    txd_q <= 1'b0;
                    tsh_q <= par_on ? {1'b1, tpar, tbyte} : {2'b11, tbyte};
                    tb_q <= 4'h1;
                    tt_q <= cfg_q.baud_div - 16'h1;
                    tload_q <= 1'b0;
                    if (ti_q < rlen - 9'h2) tcrc_q <= crc_step(tcrc_q, tbyte);
                end
            end else if (tt_q != 16'h0) begin
                tt_q <= tt_q - 16'h1;
            end else if (tb_q == tnb) begin
                tload_q <= 1'b1;
                ti_q <= ti_q + 9'h1;
            end else begin
                txd_q <= tsh_q[0];
                tsh_q <= {1'b1, tsh_q[9:1]};
                tb_q <= tb_q + 4'h1;
                tt_q <= cfg_q.baud_div - 16'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sp_q <= SP_RST;
            splo_q <= SPLO_RST;
            sphi_q <= SPHI_RST;
            cfg_reg_q <= CFG_INIT;
            coil_q <= 1'b0;
        end else if (ce) begin
            if (wr_en && value_ok(wr_a, wr_v)) begin
                if (wr_a == REG_SP) sp_q <= clamp;
                else if (wr_a == REG_SPLO) splo_q <= wr_v;
                else if (wr_a == REG_SPHI) sphi_q <= wr_v;
                else if (wr_a == REG_NODE) cfg_reg_q.node <= wr_v[7:0];
                else if (wr_a == REG_PAR) cfg_reg_q.parity <= parity_t'(wr_v[1:0]);
                else if (wr_a == REG_BAUD) cfg_reg_q.baud_div <= wr_v;
            end
            if (st_q == S_DECIDE && go_ok && fc == FC_COIL) coil_q <= rv == COIL_ON;
        end
    end

    assign txd = txd_q;
    assign txd_oe = txd_oe_q;
    assign main_setpoint = sp_q;
    assign coil_state = coil_q;
endmodule

// ### modbus_rtu_slave_properties.sv
// Pin assertions for the RTU slave, bound in below the module.
// Assumes replies are only made at a bit divisor of 16.
`timescale 1ns/1ns
module modbus_rtu_slave_properties #(
    parameter int RESP_MAX = 1000,
    parameter int RELEASE_MAX = 400
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rxd,
    input wire logic txd,
    input wire logic txd_oe,
    input wire logic [15:0] main_setpoint,
    input wire logic coil_state
);
    int quiet_q, quiet_d, hold_q, hold_d;
    // Idle run of rxd, and high run of txd while driven
    assign quiet_d = rxd ? quiet_q + 1 : 0;
    assign hold_d = (txd_oe && txd) ? hold_q + 1 : 0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {quiet_q, hold_q} <= '0;
        else {quiet_q, hold_q} <= {quiet_d, hold_d};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_idle; !txd_oe |-> txd; endproperty
    a_idle: assert property (p_idle) else $error("txd low while released");
    property p_start; $rose(txd_oe) |=> (txd_oe && !txd) [*8]; endproperty
    a_start: assert property (p_start) else $error("no start bit");
    property p_gap; $rose(txd_oe) |-> quiet_q >= 624; endproperty
    a_gap: assert property (p_gap) else $error("reply inside frame silence");
    property p_resp; $rose(txd_oe) |-> quiet_q <= 752 + RESP_MAX; endproperty
    a_resp: assert property (p_resp) else $error("reply late");
    property p_release; hold_q <= RELEASE_MAX; endproperty
    a_release: assert property (p_release) else $error("line held too long");
    property p_stop; $fell(txd_oe) |-> txd && $past(txd, 16); endproperty
    a_stop: assert property (p_stop) else $error("released inside stop bit");
    property p_sp; $changed(main_setpoint) |-> !$past(txd_oe) && quiet_q > 600; endproperty
    a_sp: assert property (p_sp) else $error("setpoint moved outside a request");
    property p_rst;
        $past(rst) |-> txd && !txd_oe && !coil_state && main_setpoint == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("not quiet after reset");
endmodule
bind modbus_rtu_slave modbus_rtu_slave_properties #(.RESP_MAX(RESP_MAX),
    .RELEASE_MAX(RELEASE_MAX)) u_props (.clk(clk), .rst(rst), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe), .main_setpoint(main_setpoint), .coil_state(coil_state));

// ### tb.sv
// Bench for the RTU slave: host model on the line, scenarios as tasks.
// Assumes reset divisor set to 32 here; a broadcast moves it to 16.
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, rst = 1'b1, ext_setpoint_valid = 1'b0;
    logic rxd, txd, txd_oe, coil_state;
    logic [15:0] main_setpoint;
    int failures = 0, checked = 0;
    always #4 clk = ~clk;
    host_model hm (.clk(clk), .rxd(rxd), .txd(txd), .txd_oe(txd_oe));
    modbus_rtu_slave #(.RESP_MAX(1000), .RELEASE_MAX(400), .BAUD_DIV_INIT(16'h0020)) uut (
        .clk(clk), .rst(rst),
        .ce(1'b1), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .measured_process_value(16'h8123),
        .ext_setpoint(16'h0042), .ext_setpoint_valid(ext_setpoint_valid),
        .main_setpoint(main_setpoint), .coil_state(coil_state));
    task automatic end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // Bytes packed first byte highest; no reply expected when ne is 0
    task automatic xfer(input logic [87:0] rq, input int nr, input logic [87:0] ex,
            input int ne, input bit bad = 1'b0);
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [15:0] c;
        for (int i = nr - 1; i >= 0; i--) q.push_back(rq[8 * i +: 8]);
        for (int i = ne - 1; i >= 0; i--) e.push_back(ex[8 * i +: 8]);
        c = crc16(q) ^ {15'h0, bad};
        q = {q, c[7:0], c[15:8]};
        c = crc16(e);
        if (ne > 0) e = {e, c[7:0], c[15:8]};
        hm.send_frame(q);
        for (int i = 0; i < 250 * hm.div; i++) begin
            if (i > 45 * hm.div && !txd_oe && hm.rx_q.size() == e.size()) break;
            @(negedge clk);
        end
        cmp("reply length", 16'(e.size()), 16'(hm.rx_q.size()));
        foreach (e[i]) if (i < hm.rx_q.size()) cmp("reply byte", 16'(e[i]), 16'(hm.rx_q[i]));
        hm.rx_q = {};
        repeat (640) @(negedge clk);
    endtask
    task automatic t_rate;
        repeat (40 * hm.div) @(negedge clk);
        xfer(48'h000600140010, 6, 88'h0, 0);
        hm.div = 16;
    endtask
    task automatic t_regs;
        xfer(48'h010300010001, 6, 40'h0103028123, 5);
        ext_setpoint_valid <= 1'b1;
        xfer(48'h010300000001, 6, 40'h0103020042, 5);
        ext_setpoint_valid <= 1'b0;
        xfer(48'h010600007000, 6, 48'h010600007000, 6);
        cmp("main setpoint", 16'h270f, main_setpoint);
        xfer(48'h010600008000, 6, 48'h010600008000, 6);
        cmp("main setpoint", 16'hf831, main_setpoint);
        xfer(48'h010600010005, 6, 24'h018602, 3);
        xfer(48'h010400000001, 6, 24'h018401, 3);
        xfer(48'h050300000001, 6, 88'h0, 0);
        xfer(48'h010300000001, 6, 88'h0, 0, 1'b1);
    endtask
    task automatic t_write;
        xfer(48'h01050000ff00, 6, 48'h01050000ff00, 6);
        cmp("coil", 16'h0001, {15'h0, coil_state});
        xfer(88'h0110001000020400000064, 11, 48'h011000100002, 6);
        xfer(48'h010300100002, 6, 56'h01030400000064, 7);
        xfer(48'h010600000200, 6, 48'h010600000200, 6);
        cmp("main setpoint", 16'h0064, main_setpoint);
        xfer(48'h010600120007, 6, 48'h010600120007, 6);
        xfer(48'h070300010001, 6, 40'h0703028123, 5);
        xfer(48'h070600130001, 6, 48'h070600130001, 6);
        hm.par = 1;
        xfer(48'h070300010001, 6, 40'h0703028123, 5);
        cmp("parity errors", 16'h0000, 16'(hm.par_err));
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst <= 1'b0;
        t_rate();
        t_regs();
        t_write();
        end_sim();
    end
    initial begin
        repeat (150_000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule
